/* File: logic/ccc_calendar_clock.sv */
// Purpose: calendar clock with trim, reached over APB
// Assumes: crystal arrives as a pin level; APB on the system clock
// Notes:   time bytes seen by software are an image of the counters
//
// Added by the designer: the APB interface to the registers.

`timescale 1ns/1ps
`default_nettype none

// Function
// - control bit 7 set holds the visible time bytes still
// - clearing bit 7 copies all time bytes into the counters
// - first increment after that release comes one full second later
// - control bit 6 freezes the visible time bytes too
// - seconds bit 7 set stops the oscillator at any time
// - the halt bit comes out of reset set
// - after halt is cleared the oscillator runs one second later
// - a 32,768 Hz crystal is divided down to one second
// - trimming moves the terminal count of the single divide by 32,768 counter
// - trim magnitude is five bits in the control byte low bits
// - control bit 5 gives trim direction, one means faster
// - trim repeats every 64 minutes, one second per minute
// - magnitude N trims the first 2N minutes of the cycle
// - trimmed second is 256 cycles shorter or 128 longer
// - weekday bit 6 enables the frequency check output
// - that output is 512 Hz and ignores the trim
module ccc_calendar_clock
    import ccc_pkg::*;
#(
    parameter int P_START_CYC = START_CYC
) (
    // clock, reset, enable
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    // crystal pin
    input  wire logic              i_osc,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output var  logic              o_pready,
    output var  logic [31:0]       o_prdata,
    output var  logic              o_pslverr,
    // test output
    output var  logic              o_freq_check_output
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]  osc_sync_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  img_q [1:7];
    logic        halt_q;
    logic        ft_q;
    logic        load_q;
    logic [5:0]  cal_min_q;
    logic        freq_q;
    logic [24:0] start_cnt_q;
    ccc_osc_type osc_state_q;
    ccc_osc_type osc_state_d;
    logic [7:0]  cnt_val [1:7];
    logic        inc     [1:7];
    logic        wrap    [1:7];
    logic        sec_pulse;
    logic        square;

    // ------------------------------------------------------------
    // crystal pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_sync_q <= '0;
        end else if (i_ce) begin
            osc_sync_q <= {osc_sync_q[1:0], i_osc};
        end
    end

    wire osc_rise = osc_sync_q[1] & ~osc_sync_q[2];
    wire running  = (osc_state_q == OSC_RUN);
    // no ticks while stopped or starting
    wire tick     = osc_rise & running;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [17:0] word_idx = i_paddr[ADDR_W-1:2];
    wire [2:0]  sel      = word_idx[2:0];
    wire        hit      = (word_idx[17:3] == REG_CTRL_IDX[17:3]) && (i_paddr[1:0] == 2'b00);
    wire        acc      = i_psel & i_penable & ~pready_q;
    wire        done     = i_psel & i_penable & pready_q;
    wire        wr_en    = done & i_pwrite & hit;
    wire [7:0]  wbyte    = i_pwdata[7:0];
    wire        wr_ctrl  = wr_en && (sel == SEL_CTRL);
    wire        wr_sec   = wr_en && (sel == SEL_SEC);
    wire        wr_wday  = wr_en && (sel == SEL_WDAY);
    wire        wr_time  = wr_en && (sel != SEL_CTRL);
    wire        hold     = ctrl_q[BIT_WRITE_HOLD];
    wire        freeze   = ctrl_q[BIT_READ_FREEZE];
    wire        w_fall   = wr_ctrl & hold & ~wbyte[BIT_WRITE_HOLD];
    wire        halt_set = wr_sec & wbyte[BIT_OSC_HALT];
    wire        halt_clr = wr_sec & ~wbyte[BIT_OSC_HALT];

    wire [7:0] rd_byte =
        (sel == SEL_CTRL) ? ctrl_q
      : (sel == SEL_SEC)  ? {halt_q, img_q[1][6:0]}
      : (sel == SEL_WDAY) ? {1'b0, ft_q, 3'b000, img_q[4][2:0]}
      : img_q[sel];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (i_ce) begin
            pready_q  <= acc;
            pslverr_q <= acc & ~hit;
            if (acc) prdata_q <= hit ? {24'h00_0000, rd_byte} : '0;
        end
    end

    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata  = prdata_q;

    // ------------------------------------------------------------
    // control, halt and test bits
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= CTRL_RESET;
            halt_q <= 1'b1;
            ft_q   <= 1'b0;
            load_q <= 1'b0;
        end else if (i_ce) begin
            // trim magnitude and flags held here
            if (wr_ctrl) ctrl_q <= wbyte;
            if (wr_sec) halt_q <= wbyte[BIT_OSC_HALT];
            if (wr_wday) ft_q <= wbyte[BIT_FREQ_CHECK];
            load_q <= w_fall;
        end
    end

    // ------------------------------------------------------------
    // oscillator start and stop
    // ------------------------------------------------------------
    always_comb begin
        osc_state_d = osc_state_q;
        unique case (osc_state_q)
            OSC_HALTED: if (halt_clr) osc_state_d = OSC_START;
            OSC_START:  if (start_cnt_q == '0) osc_state_d = OSC_RUN;
            OSC_RUN:    osc_state_d = OSC_RUN;
            default:    osc_state_d = OSC_HALTED;
        endcase
        // stop takes effect at once, in any state
        if (halt_set) osc_state_d = OSC_HALTED;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_state_q <= OSC_HALTED;
            start_cnt_q <= '0;
        end else if (i_ce) begin
            osc_state_q <= osc_state_d;
            if (osc_state_q == OSC_HALTED) start_cnt_q <= 25'(P_START_CYC - 1);
            else if (start_cnt_q != '0) start_cnt_q <= start_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // divider and trim window
    // ------------------------------------------------------------
    wire [CAL_W-1:0] cal_mag  = ctrl_q[CAL_W-1:0];
    // first 2N minutes of the cycle only
    wire             in_win   = ({1'b0, cal_min_q} < {1'b0, cal_mag, 1'b0});
    // one second per minute, the minute's first
    wire             sec_adj  = in_win && (cnt_val[1] == FIELD_LO[1]);

    // divider held while the write hold is set
    ccc_prescaler u_prescaler (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_ce     (i_ce),
        .i_tick   (tick),
        .i_clear  (hold | load_q),
        .i_adjust (sec_adj),
        .i_sign   (ctrl_q[BIT_CAL_SIGN]),
        .o_sec    (sec_pulse),
        .o_square (square)
    );

    // 64 minute trim cycle, counted on minute carries
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cal_min_q <= '0;
        end else if (i_ce && wrap[1]) begin
            cal_min_q <= 6'(cal_min_q + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // calendar counters
    // ------------------------------------------------------------
    wire [7:0] date_hi = days_in_month(cnt_val[6], cnt_val[7]);

    genvar k;
    generate
        for (k = 1; k <= 7; k++) begin : g_field
            if (k == 1) begin : g_src
                assign inc[k] = sec_pulse;
            end else begin : g_src
                assign inc[k] = wrap[FIELD_SRC[k]];
            end
            ccc_bcd_field #(
                .P_LO (FIELD_LO[k])
            ) u_field (
                .i_clk      (i_clk),
                .i_rstn     (i_rstn),
                .i_ce       (i_ce),
                .i_inc      (inc[k]),
                .i_load     (load_q),
                .i_load_val (img_q[k]),
                .i_hi       ((k == 5) ? date_hi : FIELD_HI[k]),
                .o_val      (cnt_val[k]),
                .o_wrap     (wrap[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // visible time image
    // ------------------------------------------------------------
    // held image only changes by host writes
    // read freeze holds it the same way
    // fixed zero bits masked on write
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 1; i <= 7; i++) img_q[i] <= FIELD_LO[i];
        end else if (i_ce) begin
            for (int i = 1; i <= 7; i++) begin
                if (wr_time && (sel == 3'(i))) img_q[i] <= wbyte & FIELD_MASK[i];
                else if (!hold && !freeze && !load_q) img_q[i] <= cnt_val[i];
            end
        end
    end

    // gated copy of the untrimmed square
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            freq_q <= 1'b0;
        end else if (i_ce) begin
            freq_q <= ft_q & square;
        end
    end

    assign o_freq_check_output = freq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // full-second trim timing is too long for short runs; these guard
    // the control paths that such runs do reach
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_hold_image_still: assert property (
        hold && !wr_time |=> $stable(img_q[1]))
        else $error("held image changed");

    a_release_loads: assert property (
        load_q && i_ce |=> cnt_val[2] == $past(img_q[2]))
        else $error("counters not loaded on release");

    a_no_early_tick: assert property (
        (hold || load_q) |-> !sec_pulse)
        else $error("second counted during hold");

    a_freeze_image: assert property (
        freeze && !wr_time |=> $stable(img_q[2]))
        else $error("frozen image changed");

    a_image_follows: assert property (
        !hold && !freeze && !load_q && !wr_time && i_ce |=> img_q[1] == $past(cnt_val[1]))
        else $error("image did not follow counters");

    a_halt_stops: assert property (
        halt_q |-> !tick && !sec_pulse)
        else $error("tick while halted");

    a_start_delay: assert property (
        $fell(halt_q) |-> !running [*8])
        else $error("oscillator started too soon");

    a_trim_window: assert property (
        sec_adj |-> cal_min_q < 6'(2 * cal_mag))
        else $error("trim outside window");

    a_freq_gated: assert property (
        !ft_q && i_ce |=> !o_freq_check_output)
        else $error("test output active while disabled");

    a_sec_range: assert property (
        cnt_val[1][3:0] <= 4'h9 && cnt_val[1] <= FIELD_HI[1])
        else $error("seconds left BCD range");

    a_load_year: assert property (
        load_q && i_ce |=> cnt_val[7] == $past(img_q[7]))
        else $error("year counter not loaded on release");

    a_load_once: assert property (
        load_q && i_ce |=> !load_q)
        else $error("load repeated after release");

    a_unfreeze_no_load: assert property (
        $fell(freeze) && !$past(hold) |-> !load_q)
        else $error("read freeze release loaded counters");

    a_stop_at_once: assert property (
        halt_set && i_ce |=> !running)
        else $error("oscillator ran after stop");

    a_square_still: assert property (
        halt_q |=> $stable(square))
        else $error("test square moved while stopped");

    a_trim_zero: assert property (
        cal_mag == '0 |-> !sec_adj)
        else $error("trim with zero magnitude");
endmodule : ccc_calendar_clock
`default_nettype wire

/* File: logic/ccc_pkg.sv */
// Purpose: shared constants for the calendar clock with calibration
// Assumes: 20 MHz system clock, 32,768 Hz crystal sampled as a pin
// Notes:   register indices are word indices; byte address = 4 * index
package ccc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 20;
    localparam logic [17:0] REG_CTRL_IDX = 18'h1_fff8;
    localparam logic [17:0] REG_SEC_IDX  = 18'h1_fff9;
    localparam logic [17:0] REG_MIN_IDX  = 18'h1_fffa;
    localparam logic [17:0] REG_HOUR_IDX = 18'h1_fffb;
    localparam logic [17:0] REG_WDAY_IDX = 18'h1_fffc;
    localparam logic [17:0] REG_DATE_IDX = 18'h1_fffd;
    localparam logic [17:0] REG_MON_IDX  = 18'h1_fffe;
    localparam logic [17:0] REG_YEAR_IDX = 18'h1_ffff;
    localparam logic [2:0]  SEL_CTRL     = 3'h0;
    localparam logic [2:0]  SEL_SEC      = 3'h1;
    localparam logic [2:0]  SEL_WDAY     = 3'h4;
    localparam logic [2:0]  SEL_DATE     = 3'h5;
    localparam logic [2:0]  SEL_MON      = 3'h6;
    localparam logic [2:0]  SEL_YEAR     = 3'h7;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_WRITE_HOLD  = 7;
    localparam int BIT_READ_FREEZE = 6;
    localparam int BIT_CAL_SIGN    = 5;
    localparam int CAL_W           = 5;
    localparam int BIT_OSC_HALT    = 7;
    localparam int BIT_FREQ_CHECK  = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ------------------------------------------------------------
    // counter fields, index 1 seconds .. 7 year
    // ------------------------------------------------------------
    localparam logic [7:0] FIELD_LO   [1:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] FIELD_HI   [1:7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    localparam logic [7:0] FIELD_MASK [1:7] = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
    localparam int         FIELD_SRC  [1:7] = '{0, 1, 2, 3, 3, 5, 6};
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          OSC_HZ        = 32768;
    localparam int          CAL_POS_CYC   = 256;
    localparam int          CAL_NEG_CYC   = 128;
    localparam int          CAL_CYCLE_MIN = 64;
    localparam int          FREQ_DIV      = 32;
    localparam int          PRE_W         = 16;
    localparam longint      START_NS      = 1000000000;
    localparam longint      CLK_PERIOD_NS = 50;
    localparam int          START_CYC     = int'(START_NS / CLK_PERIOD_NS);
    // ------------------------------------------------------------
    // oscillator control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_HALTED = 2'b00,
        OSC_START  = 2'b01,
        OSC_RUN    = 2'b11
    } ccc_osc_type;

    // last day of the month, leap years every fourth year
    function automatic logic [7:0] days_in_month(input logic [7:0] mon,
                                                 input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == 8'h02) days_in_month = leap ? 8'h29 : 8'h28;
        else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
            days_in_month = 8'h30;
        else days_in_month = 8'h31;
    endfunction : days_in_month
endpackage : ccc_pkg

/* File: logic/ccc_bcd_field.sv */
// Purpose: one two-digit BCD counter field with load and wrap
// Assumes: upper bound may change at run time (day of month)
// Notes:   o_wrap is combinational and feeds the next field's increment
`timescale 1ns/1ps
`default_nettype none
module ccc_bcd_field #(
    parameter logic [7:0] P_LO = 8'h00
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // control
    input  wire logic       i_inc,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    input  wire logic [7:0] i_hi,
    // state
    output var  logic [7:0] o_val,
    output logic            o_wrap
);
    logic [7:0] val_q;
    logic [7:0] val_d;
    wire        at_top = (val_q >= i_hi);

    assign o_wrap = i_inc & at_top;
    assign o_val  = val_q;
    assign val_d  = at_top ? P_LO
                  : (val_q[3:0] == 4'h9) ? {val_q[7:4] + 4'h1, 4'h0}
                  : {val_q[7:4], val_q[3:0] + 4'h1};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            val_q <= P_LO;
        end else if (i_ce) begin
            if (i_load) val_q <= i_load_val;
            else if (i_inc) val_q <= val_d;
        end
    end
endmodule : ccc_bcd_field
`default_nettype wire

/* File: logic/ccc_prescaler.sv */
// Purpose: crystal divider with periodic correction and test square wave
// Assumes: i_tick is one cycle per crystal period, already synchronised
// Notes:   the test square counts raw ticks so trimming never moves it
`timescale 1ns/1ps
`default_nettype none
module ccc_prescaler
    import ccc_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // timebase control
    input  wire logic i_tick,
    input  wire logic i_clear,
    input  wire logic i_adjust,
    input  wire logic i_sign,
    // outputs
    output logic      o_sec,
    output var  logic o_square
);
    localparam logic [PRE_W-1:0] TERM_NOM = PRE_W'(OSC_HZ - 1);
    // trimmed second 256 shorter or 128 longer
    localparam logic [PRE_W-1:0] TERM_POS = PRE_W'(OSC_HZ - CAL_POS_CYC - 1);
    localparam logic [PRE_W-1:0] TERM_NEG = PRE_W'(OSC_HZ + CAL_NEG_CYC - 1);

    logic [PRE_W-1:0] cnt_q;
    logic [4:0]       sq_cnt_q;
    logic             sq_q;
    // divider trim: a lower terminal count shortens the second, a higher one stretches it
    wire [PRE_W-1:0]  term = !i_adjust ? TERM_NOM : (i_sign ? TERM_POS : TERM_NEG);

    assign o_sec    = i_tick & ~i_clear & (cnt_q >= term);
    assign o_square = sq_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            if (i_clear) cnt_q <= '0;
            else if (o_sec) cnt_q <= '0;
            else if (i_tick) cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sq_cnt_q <= '0;
            sq_q     <= 1'b0;
        end else if (i_ce && i_tick) begin
            sq_cnt_q <= sq_cnt_q + 1'b1;
            if (sq_cnt_q == 5'(FREQ_DIV - 1)) sq_q <= ~sq_q;
        end
    end
endmodule : ccc_prescaler
`default_nettype wire

/* File: bench/ccc_crystal_model.sv */
// Purpose: free running crystal seen at the clock's oscillator pin
// Assumes: period of five system clocks, well under a quarter rate
// Notes:   offset start keeps crystal edges off the system clock edges
`timescale 1ns/1ps
`default_nettype none
module ccc_crystal_model #(
    parameter int P_HALF_NS = 125
) (
    // crystal pin
    output var logic o_osc
);
    // ------------------------------------------------------------
    // oscillator
    // ------------------------------------------------------------
    // crystal square wave
    initial begin
        o_osc = 1'b0;
        #7;
        forever #(P_HALF_NS) o_osc = ~o_osc;
    end
endmodule : ccc_crystal_model
`default_nettype wire

/* File: bench/test_ccc_calendar_clock.sv */
// Purpose: register, load, freeze, start, halt and test output checks
// Assumes: crystal period of 5 clocks, so 32 crystal edges = 160 clocks
// Notes:   a full second is too long for this run; no increment is expected
`timescale 1ns/1ps
`default_nettype none
module test_ccc_calendar_clock;
    import ccc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int     START = 2000;
    logic              clk;
    logic              rst_n;
    logic              osc;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              fco;
    int                err_count;
    int                comparisons;
    int                n;
    logic [31:0]       r;
    logic              e;
    logic [7:0]        rst_exp [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0]        tv [8] = '{8'h00, 8'hd8, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};

    ccc_crystal_model xtal (.o_osc(osc));
    ccc_calendar_clock #(.P_START_CYC(START)) uut (
        .i_clk(clk), .i_rstn(rst_n), .i_ce(1'b1), .i_osc(osc),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .o_freq_check_output(fco));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            err_count++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [17:0] idx, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, {idx, 2'b00}, d, x, y);
    endtask : wr

    task automatic chk(input logic [17:0] idx, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b0, {idx, 2'b00}, 8'h00, x, y);
        check(x, {24'h00_0000, d});
    endtask : chk

    // cycles until the test output changes, lim if it never does
    task automatic wait_tog(input int lim, output int k);
        logic s;
        s = fco;
        k = 0;
        while (fco === s && k < lim) begin
            @(posedge clk);
            k++;
        end
    endtask : wait_tog
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) chk(REG_CTRL_IDX + 18'(i), rst_exp[i]);
        apb(1'b0, 20'h0_0100, 8'h00, r, e);
        check({r[30:0], e}, 32'h0000_0001);
        wr(REG_CTRL_IDX, 8'h80);
        for (int i = 1; i < 8; i++) wr(REG_CTRL_IDX + 18'(i), tv[i]);
        for (int i = 1; i < 8; i++) chk(REG_CTRL_IDX + 18'(i), tv[i]);
        wr(REG_CTRL_IDX, 8'h00);
        for (int i = 1; i < 8; i++) chk(REG_CTRL_IDX + 18'(i), tv[i]);
        wr(REG_CTRL_IDX, 8'h40);
        wr(REG_MIN_IDX, 8'h11);
        wr(REG_CTRL_IDX, 8'h00);
        chk(REG_MIN_IDX, 8'h59);
        wr(REG_CTRL_IDX, 8'h80);
        wr(REG_WDAY_IDX, 8'h47);
        wr(REG_CTRL_IDX, 8'h00);
        chk(REG_WDAY_IDX, 8'h47);
        wr(REG_SEC_IDX, 8'h58);
        wait_tog(START + 400, n);
        check(32'(n >= START - 5 && n <= START + 200), 32'h1);
        wait_tog(400, n);
        check(n, 32'd160);
        wr(REG_CTRL_IDX, 8'h3f);
        chk(REG_CTRL_IDX, 8'h3f);
        wait_tog(400, n);
        wait_tog(400, n);
        check(n, 32'd160);
        wr(REG_CTRL_IDX, 8'h1f);
        chk(REG_CTRL_IDX, 8'h1f);
        chk(REG_SEC_IDX, 8'h58);
        wr(REG_SEC_IDX, 8'hd8);
        repeat (3) @(posedge clk);
        wait_tog(1000, n);
        check(n, 32'd1000);
        chk(REG_SEC_IDX, 8'hd8);
        wr(REG_CTRL_IDX, 8'h80);
        wr(REG_SEC_IDX, 8'h80);
        wr(REG_CTRL_IDX, 8'h05);
        chk(REG_SEC_IDX, 8'h80);
        chk(REG_CTRL_IDX, 8'h05);
        stop_test();
    end
endmodule : test_ccc_calendar_clock
`default_nettype wire
